// file: core/prd_decode.sv
// register-transfer decode with one-cycle prefix holding register
// assumes fetch delivers one 16-bit word per clock and register modules
// answer a source read in the same cycle as src_rd_q
//
// Summary of operation
// (RQ1) System and peripheral registers are named only by index fields of the word.
// (RQ2) Each 16-bit word is taken in one cycle; a prefixed operation spans two words.
// (RQ3) The prefix holding register keeps a written value one cycle, then reads zero.
// (RQ4) A 16-bit immediate is prefix byte above the instruction's 8-bit immediate.
// (RQ5) With no prefix written before, the immediate high byte is zero.
// (RQ6) A branch is absolute only if the prefix was written the cycle before.
// (RQ7) Destination index above 07h or source above 0Fh takes high bits from the prefix.
// (RQ8) An 8-bit destination at subindex 0h to 7h loads an immediate in one cycle.
// (RQ9) Software writes the prefix first to load an 8-bit register at subindex 8h or up.
// (RQ10) The general word register is 16 bits with separately written byte views.
// (RQ11) A read-only view gives the general word register with bytes exchanged.
// (RQ12) A view gives the general word register low byte sign-extended to 16 bits.
// (RQ13) A 16-bit source moved to an 8-bit destination gives its low byte.
// (RQ14) Software copies a word into the general register to reach its high byte.
// (RQ15) Indirect access uses pointer contents as address; a stack read pops.
// (RQ16) Prefix index bits sit above the instruction's own index field.
`default_nettype none

module prd_decode
  import prd_pkg::*;
(
  input wire logic core_clk, // core clock, 10 MHz
  input wire logic rstn, // async reset, active low
  input wire logic instr_valid, // instruction word present
  input wire logic [INSTR_W-1:0] instr_word, // instruction word
  input wire logic [DATA_W-1:0] src_rdata, // source or memory read data
  input wire logic [DATA_W-1:0] dp_value, // data_memory_pointer contents
  input wire logic [DATA_W-1:0] sp_value, // stack_top_pointer contents
  output logic src_rd_q, // register source read strobe
  output logic [MOD_W-1:0] src_mod_q, // source module
  output logic [IDX_W-1:0] src_idx_q, // full source index
  output logic mem_rd_q, // indirect data memory read
  output logic [DATA_W-1:0] mem_addr_q, // indirect read address
  output logic sp_pop_q, // stack pop request
  output logic dst_wr_q, // register destination write strobe
  output logic [MOD_W-1:0] dst_mod_q, // destination module
  output logic [IDX_W-1:0] dst_idx_q, // full destination index
  output logic [DATA_W-1:0] wr_data_q, // write data or branch target
  output logic mem_wr_q, // indirect data memory write
  output logic [DATA_W-1:0] mem_wr_addr_q, // indirect write address
  output logic branch_q, // branch request
  output logic branch_abs_q, // branch is absolute
  output logic [BYTE_W-1:0] prefix_hold_register_q, // prefix data byte
  output logic [SEL_W-1:0] prefix_sel_q, // prefix index select
  output logic prefix_written_q // prefix holds a value this cycle
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic hit(input logic [MOD_W-1:0] m, input logic [IDX_W-1:0] i,
                               input logic [MOD_W-1:0] wm, input logic [IDX_W-1:0] wi);
    hit = (m == wm) && (i == wi);
  endfunction : hit

  function automatic logic [DATA_W-1:0] zext(input logic [BYTE_W-1:0] b);
    zext = {{BYTE_W{1'b0}}, b};
  endfunction : zext

  // ************************************************************
  // execute-stage state
  // ************************************************************
  logic x_valid_q;
  logic x_imm_q;
  logic x_abs_q;
  logic [DATA_W-1:0] x_imm_val_q;
  logic [MOD_W-1:0] x_dst_mod_q;
  logic [IDX_W-1:0] x_dst_idx_q;
  logic [MOD_W-1:0] x_src_mod_q;
  logic [IDX_W-1:0] x_src_idx_q;

  logic pfx_load;
  logic [BYTE_W-1:0] pfx_data_d;
  logic [SEL_W-1:0] pfx_sel_d;
  logic [MOD_W-1:0] dec_src_mod;
  logic [IDX_W-1:0] dec_src_idx;
  logic [MOD_W-1:0] dec_dst_mod;
  logic [IDX_W-1:0] dec_dst_idx;
  logic dec_reg_src;
  logic [DATA_W-1:0] x_val;
  logic [DATA_W-1:0] gr_word;
  logic [DATA_W-1:0] gr_swap;
  logic [DATA_W-1:0] gr_sext;
  logic gr_wr_word;
  logic gr_wr_high;
  logic gr_wr_low;
  logic x_to_pfx;
  logic x_to_grp;
  logic x_to_mem;
  logic x_to_branch;

  // ************************************************************
  // prefix forward
  // ************************************************************
  // the prefix written by the instruction now executing is what the
  // instruction now being decoded sees; nothing later can see it
  assign x_to_pfx = x_valid_q && (x_dst_mod_q == MOD_PFX);
  assign pfx_load = x_to_pfx;
  assign pfx_data_d = pfx_load ? x_val[BYTE_W-1:0] : PFX_RST; // RQ5
  assign pfx_sel_d = pfx_load ? x_dst_idx_q[SEL_W-1:0] : PFX_SEL_RST;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prefix_hold_register_q <= PFX_RST;
      prefix_sel_q <= PFX_SEL_RST;
      prefix_written_q <= 1'b0;
    end
    else
    begin
      prefix_hold_register_q <= pfx_data_d; // RQ3
      prefix_sel_q <= pfx_sel_d; // RQ3
      prefix_written_q <= pfx_load; // RQ3
    end
  end

  // ************************************************************
  // decode
  // ************************************************************
  assign dec_reg_src = instr_word[F_SRC_REG_BIT];
  assign dec_src_mod = instr_word[F_SRC_MOD_LSB +: MOD_W]; // RQ1
  assign dec_dst_mod = instr_word[F_DST_MOD_LSB +: MOD_W]; // RQ1
  assign dec_src_idx = {pfx_sel_d[PFX_SEL_SRC_BIT],
                        instr_word[F_SRC_IDX_LSB +: SRC_IDX_W]}; // RQ7 RQ16
  assign dec_dst_idx = {pfx_sel_d[PFX_SEL_DST_LSB +: PFX_SEL_DST_W],
                        instr_word[F_DST_IDX_LSB +: DST_IDX_W]}; // RQ7 RQ8 RQ16

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      x_valid_q <= 1'b0;
      x_imm_q <= 1'b0;
      x_abs_q <= 1'b0;
      x_imm_val_q <= WORD_RST;
      x_dst_mod_q <= '0;
      x_dst_idx_q <= '0;
      x_src_mod_q <= '0;
      x_src_idx_q <= '0;
    end
    else
    begin
      x_valid_q <= instr_valid; // RQ2
      x_imm_q <= !dec_reg_src;
      x_abs_q <= pfx_load; // RQ6
      x_imm_val_q <= {pfx_data_d, instr_word[F_IMM_LSB +: BYTE_W]}; // RQ4
      x_dst_mod_q <= dec_dst_mod;
      x_dst_idx_q <= dec_dst_idx;
      x_src_mod_q <= dec_src_mod;
      x_src_idx_q <= dec_src_idx;
    end
  end

  // ************************************************************
  // source requests
  // ************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_rd_q <= 1'b0;
      src_mod_q <= '0;
      src_idx_q <= '0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= WORD_RST;
      sp_pop_q <= 1'b0;
    end
    else
    begin
      src_rd_q <= instr_valid && dec_reg_src && dec_src_mod != MOD_GRP
                  && dec_src_mod != MOD_MEM; // RQ1
      src_mod_q <= dec_src_mod;
      src_idx_q <= dec_src_idx;
      mem_rd_q <= instr_valid && dec_reg_src && (hit(dec_src_mod, dec_src_idx, MOD_MEM, MEMX_DP)
                  || hit(dec_src_mod, dec_src_idx, MOD_MEM, MEMX_SP)); // RQ15
      mem_addr_q <= hit(dec_src_mod, dec_src_idx, MOD_MEM, MEMX_SP) ? sp_value
                    : dp_value; // RQ15
      sp_pop_q <= instr_valid && dec_reg_src
                  && hit(dec_src_mod, dec_src_idx, MOD_MEM, MEMX_SP); // RQ15
    end
  end

  // ************************************************************
  // source value
  // ************************************************************
  always_comb
  begin
    x_val = src_rdata;
    if (x_imm_q)
    begin
      x_val = x_imm_val_q; // RQ4
    end
    else if (x_src_mod_q == MOD_GRP)
    begin
      unique case (x_src_idx_q)
        GRX_WORD: x_val = gr_word;
        GRX_HIGH: x_val = zext(gr_word[DATA_W-1:BYTE_W]); // RQ10
        GRX_LOW: x_val = zext(gr_word[BYTE_W-1:0]); // RQ10
        GRX_SWAP: x_val = gr_swap; // RQ11
        GRX_SEXT: x_val = gr_sext; // RQ12
        default: x_val = WORD_RST;
      endcase
    end
  end

  // ************************************************************
  // general word register
  // ************************************************************
  assign x_to_grp = x_valid_q && (x_dst_mod_q == MOD_GRP);
  assign x_to_mem = x_valid_q && hit(x_dst_mod_q, x_dst_idx_q, MOD_MEM, MEMX_DP);
  assign x_to_branch = x_valid_q && hit(x_dst_mod_q, x_dst_idx_q, MOD_SYS, IDX_BRANCH);
  // swapped and sign-extended views are read-only: writes to them drop
  assign gr_wr_word = x_to_grp && (x_dst_idx_q == GRX_WORD);
  assign gr_wr_high = x_to_grp && (x_dst_idx_q == GRX_HIGH); // RQ13
  assign gr_wr_low = x_to_grp && (x_dst_idx_q == GRX_LOW); // RQ13

  prd_word_reg u_word_reg (
    .core_clk (core_clk),
    .rstn (rstn),
    .wr_word (gr_wr_word),
    .wr_high (gr_wr_high),
    .wr_low (gr_wr_low),
    .wr_data (x_val),
    .word_q (gr_word),
    .swap_view (gr_swap),
    .sext_view (gr_sext)
  );

  // ************************************************************
  // destination writes
  // ************************************************************
  // byte-wide destinations take wr_data_q low byte, so a word source
  // lands as its low byte without extra logic here
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dst_wr_q <= 1'b0;
      dst_mod_q <= '0;
      dst_idx_q <= '0;
      wr_data_q <= WORD_RST;
      mem_wr_q <= 1'b0;
      mem_wr_addr_q <= WORD_RST;
      branch_q <= 1'b0;
      branch_abs_q <= 1'b0;
    end
    else
    begin
      dst_wr_q <= x_valid_q && !x_to_pfx && !x_to_grp && x_dst_mod_q != MOD_MEM
                  && !x_to_branch; // RQ1 RQ8
      dst_mod_q <= x_dst_mod_q;
      dst_idx_q <= x_dst_idx_q;
      wr_data_q <= x_val; // RQ13
      mem_wr_q <= x_to_mem; // RQ15
      mem_wr_addr_q <= dp_value; // RQ15
      branch_q <= x_to_branch;
      branch_abs_q <= x_to_branch && x_abs_q; // RQ6
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_prefix_clears: assert property (@(posedge core_clk) disable iff (!rstn) // RQ3
    prefix_written_q && !pfx_load |=> !prefix_written_q && prefix_hold_register_q == 8'h00
      && prefix_sel_q == 3'h0)
    else $error("prefix held longer than one cycle");
  a_imm_high_byte: assert property (@(posedge core_clk) disable iff (!rstn) // RQ4
    instr_valid && pfx_load && !instr_word[15] ##1 x_valid_q |->
      x_imm_val_q == {$past(x_val[7:0]), $past(instr_word[7:0])})
    else $error("immediate high byte not from prefix");
  a_imm_default_zero: assert property (@(posedge core_clk) disable iff (!rstn) // RQ5
    instr_valid && !pfx_load |=> x_imm_val_q[15:8] == 8'h00)
    else $error("immediate high byte not zero without prefix");
  a_branch_kind: assert property (@(posedge core_clk) disable iff (!rstn) // RQ6
    branch_q |-> branch_abs_q == $past(pfx_load, 2))
    else $error("branch kind does not follow prefix write");
  a_dst_index_join: assert property (@(posedge core_clk) disable iff (!rstn) // RQ7
    dst_wr_q |-> dst_idx_q == {$past(pfx_sel_d[2:1], 2), $past(instr_word[14:12], 2)})
    else $error("destination index not joined from prefix");
  a_src_index_join: assert property (@(posedge core_clk) disable iff (!rstn) // RQ16
    src_rd_q |-> src_idx_q == {$past(pfx_sel_d[0]), $past(instr_word[7:4])})
    else $error("source index not joined from prefix");
  a_one_cycle_write: assert property (@(posedge core_clk) disable iff (!rstn) // RQ2
    instr_valid && !instr_word[15] && instr_word[11:8] < 4'h8 |-> ##2 dst_wr_q
      && wr_data_q[7:0] == $past(instr_word[7:0], 2))
    else $error("immediate transfer not done in one slot");
  a_stack_pop: assert property (@(posedge core_clk) disable iff (!rstn) // RQ15
    sp_pop_q |-> mem_rd_q && mem_addr_q == $past(sp_value))
    else $error("stack read does not pop at pointer");
  a_byte_low: assert property (@(posedge core_clk) disable iff (!rstn) // RQ13
    x_valid_q && !x_imm_q && x_src_mod_q != MOD_GRP |=> wr_data_q == $past(src_rdata))
    else $error("register source data not passed");

  c_prefixed_imm: cover property (@(posedge core_clk) disable iff (!rstn)
    pfx_load && instr_valid && !instr_word[15] ##2 dst_wr_q && wr_data_q[15:8] != 8'h00);
  c_abs_branch: cover property (@(posedge core_clk) disable iff (!rstn)
    branch_q && branch_abs_q);
  c_swap_read: cover property (@(posedge core_clk) disable iff (!rstn)
    x_valid_q && !x_imm_q && x_src_mod_q == MOD_GRP && x_src_idx_q == GRX_SWAP);

endmodule : prd_decode

`default_nettype wire

// file: core/prd_pkg.sv
// constants for the prefix/register-transfer decode block
// assumes one core clock and one asynchronous active-low reset
`default_nettype none

package prd_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int INSTR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int MOD_W = 4;
  localparam int DST_IDX_W = 3;
  localparam int SRC_IDX_W = 4;
  localparam int IDX_W = 5;
  localparam int SEL_W = 3;

  // ************************************************************
  // instruction word fields
  // ************************************************************
  localparam int F_SRC_REG_BIT = 15;
  localparam int F_DST_IDX_LSB = 12;
  localparam int F_DST_MOD_LSB = 8;
  localparam int F_SRC_IDX_LSB = 4;
  localparam int F_SRC_MOD_LSB = 0;
  localparam int F_IMM_LSB = 0;

  // ************************************************************
  // prefix index-select fields (index n of the prefix write)
  // ************************************************************
  localparam int PFX_SEL_SRC_BIT = 0;
  localparam int PFX_SEL_DST_LSB = 1;
  localparam int PFX_SEL_DST_W = 2;

  // ************************************************************
  // module codes and subindexes
  // ************************************************************
  localparam logic [MOD_W-1:0] MOD_SYS = 4'h8;
  localparam logic [MOD_W-1:0] MOD_PFX = 4'hB;
  localparam logic [MOD_W-1:0] MOD_MEM = 4'hC;
  localparam logic [MOD_W-1:0] MOD_GRP = 4'hD;
  localparam logic [IDX_W-1:0] IDX_BRANCH = 5'h04;
  localparam logic [IDX_W-1:0] MEMX_DP = 5'h00;
  localparam logic [IDX_W-1:0] MEMX_SP = 5'h01;
  localparam logic [IDX_W-1:0] GRX_WORD = 5'h00;
  localparam logic [IDX_W-1:0] GRX_HIGH = 5'h01;
  localparam logic [IDX_W-1:0] GRX_LOW = 5'h02;
  localparam logic [IDX_W-1:0] GRX_SWAP = 5'h03;
  localparam logic [IDX_W-1:0] GRX_SEXT = 5'h04;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [BYTE_W-1:0] PFX_RST = 8'h00;
  localparam logic [SEL_W-1:0] PFX_SEL_RST = 3'h0;
  localparam logic [DATA_W-1:0] GR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;

endpackage : prd_pkg

`default_nettype wire

// file: core/prd_word_reg.sv
// general word register with byte, swapped and sign-extended views
// assumes write strobes are one-hot from the decoder on core_clk
`default_nettype none

module prd_word_reg
  import prd_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic wr_word, // load whole word
  input wire logic wr_high, // load high byte from data low byte
  input wire logic wr_low, // load low byte from data low byte
  input wire logic [DATA_W-1:0] wr_data, // write data
  output logic [DATA_W-1:0] word_q, // stored word
  output logic [DATA_W-1:0] swap_view, // bytes exchanged
  output logic [DATA_W-1:0] sext_view // low byte sign-extended
);

  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_q <= GR_RST;
    end
    else if (wr_word)
    begin
      word_q <= wr_data;
    end
    else if (wr_high)
    begin
      word_q[DATA_W-1:BYTE_W] <= wr_data[BYTE_W-1:0]; // RQ10
    end
    else if (wr_low)
    begin
      word_q[BYTE_W-1:0] <= wr_data[BYTE_W-1:0]; // RQ10
    end
  end

  // ************************************************************
  // read-only views
  // ************************************************************
  assign swap_view = {word_q[BYTE_W-1:0], word_q[DATA_W-1:BYTE_W]}; // RQ11
  assign sext_view = {{BYTE_W{word_q[BYTE_W-1]}}, word_q[BYTE_W-1:0]}; // RQ12

  a_high_byte_write: assert property (@(posedge core_clk) disable iff (!rstn) // RQ10
    wr_high && !wr_word |=> word_q[15:8] == $past(wr_data[7:0])
      && word_q[7:0] == $past(word_q[7:0]))
    else $error("high byte view write wrong");
  a_swap_view: assert property (@(posedge core_clk) disable iff (!rstn) // RQ11
    swap_view[15:8] == word_q[7:0] && swap_view[7:0] == word_q[15:8])
    else $error("swapped view mismatch");
  a_sext_view: assert property (@(posedge core_clk) disable iff (!rstn) // RQ12
    sext_view[15:8] == (word_q[7] ? 8'hFF : 8'h00))
    else $error("sign extension wrong");

endmodule : prd_word_reg

`default_nettype wire

// file: bench/prd_partner.sv
// far-side model: register modules, data memory and stack pointer of the core
// assumes read data is wanted in the cycle in which a read strobe stands
`default_nettype none

module prd_partner
  import prd_pkg::*;
#(
  parameter logic [DATA_W-1:0] PTR_BASE = 16'h0200,
  parameter logic [DATA_W-1:0] STK_BASE = 16'h0100
)
(
  input wire logic core_clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic src_rd_q, // register read strobe
  input wire logic [MOD_W-1:0] src_mod_q, // source module
  input wire logic [IDX_W-1:0] src_idx_q, // full source index
  input wire logic mem_rd_q, // memory read strobe
  input wire logic [DATA_W-1:0] mem_addr_q, // memory read address
  input wire logic sp_pop_q, // stack pop strobe
  output logic [DATA_W-1:0] src_rdata, // read data
  output logic [DATA_W-1:0] ptr_value, // data pointer contents
  output logic [DATA_W-1:0] stk_value // stack pointer contents
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DATA_W-1:0] ptr_q;
  logic [DATA_W-1:0] stk_q;
  logic [DATA_W-1:0] noise_q;

  assign ptr_value = ptr_q;
  assign stk_value = stk_q;

  // data pointer steps after a read through it, so a stale address shows
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ptr_q <= PTR_BASE;
    else if (mem_rd_q && !sp_pop_q)
      ptr_q <= ptr_q + 16'h0001;
  end

  // pop moves the pointer one word down once the read is done
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      stk_q <= STK_BASE;
    else if (sp_pop_q)
      stk_q <= stk_q - 16'h0001;
  end

  // idle bus toggles every cycle so stale data never passes for valid
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      noise_q <= 16'h5A5A;
    else
      noise_q <= {noise_q[14:0], ~noise_q[15]};
  end

  always_comb
  begin
    if (src_rd_q)
      src_rdata = {3'h5, src_idx_q, 4'h6, src_mod_q};
    else if (mem_rd_q)
      src_rdata = mem_addr_q ^ 16'h5AA5;
    else
      src_rdata = noise_q;
  end

endmodule : prd_partner

`default_nettype wire

// file: bench/prd_decode_bench.sv
// self-checking bench for the prefix/register-transfer decoder
// assumes the partner answers reads in the strobe cycle; words fed from a queue
`default_nettype none

module prd_decode_bench
  import prd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [DATA_W-1:0] PTR_BASE = 16'h0200;
  localparam logic [DATA_W-1:0] STK_BASE = 16'h0100;
  localparam logic [MOD_W-1:0] M_PRE = 4'hB; // prefix module

  logic core_clk;
  logic rstn;
  logic instr_valid;
  logic [INSTR_W-1:0] instr_word;
  logic [DATA_W-1:0] src_rdata, ptr_value, stk_value, mem_addr_q, wr_data_q, mem_wr_addr_q;
  logic src_rd_q, mem_rd_q, sp_pop_q, dst_wr_q, mem_wr_q, branch_q, branch_abs_q;
  logic [MOD_W-1:0] src_mod_q, dst_mod_q;
  logic [IDX_W-1:0] src_idx_q, dst_idx_q;
  logic [BYTE_W-1:0] prefix_hold_register_q;
  logic [SEL_W-1:0] prefix_sel_q;
  logic prefix_written_q;
  logic [INSTR_W:0] wq[$];
  int num_errors = 0;
  int samples_checked = 0;

  prd_decode u_prd_decode (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .src_rdata(src_rdata), .dp_value(ptr_value),
    .sp_value(stk_value), .src_rd_q(src_rd_q), .src_mod_q(src_mod_q), .src_idx_q(src_idx_q),
    .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .sp_pop_q(sp_pop_q), .dst_wr_q(dst_wr_q),
    .dst_mod_q(dst_mod_q), .dst_idx_q(dst_idx_q), .wr_data_q(wr_data_q), .mem_wr_q(mem_wr_q),
    .mem_wr_addr_q(mem_wr_addr_q), .branch_q(branch_q), .branch_abs_q(branch_abs_q),
    .prefix_hold_register_q(prefix_hold_register_q), .prefix_sel_q(prefix_sel_q),
    .prefix_written_q(prefix_written_q));

  prd_partner #(.PTR_BASE(PTR_BASE), .STK_BASE(STK_BASE)) u_prd_partner (.core_clk(core_clk),
    .rstn(rstn), .src_rd_q(src_rd_q), .src_mod_q(src_mod_q), .src_idx_q(src_idx_q),
    .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .sp_pop_q(sp_pop_q), .src_rdata(src_rdata),
    .ptr_value(ptr_value), .stk_value(stk_value));

  // ************************************************************
  // clock, word feeder, helpers
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // one queue entry per cycle; top bit clear gives an idle cycle
  always @(posedge core_clk)
  begin
    if (wq.size() > 0)
    begin
      instr_valid <= wq[0][INSTR_W];
      instr_word <= wq[0][INSTR_W-1:0];
      void'(wq.pop_front());
    end
    else
    begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
    end
  end

  function automatic logic [INSTR_W:0] rw(logic [3:0] dm, logic [2:0] di, logic [3:0] sm,
                                          logic [3:0] si);
    return {2'b11, di, dm, si, sm};
  endfunction : rw

  function automatic logic [INSTR_W:0] im(logic [3:0] dm, logic [2:0] di, logic [7:0] imm);
    return {2'b10, di, dm, imm};
  endfunction : im

  function automatic logic [DATA_W-1:0] regv(logic [3:0] m, logic [4:0] i);
    return {3'h5, i, 4'h6, m};
  endfunction : regv

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_wr(input logic [3:0] m, input logic [4:0] i, input logic [15:0] d);
    chk(dst_wr_q, 1'b1);
    chk(dst_mod_q, m);
    chk(dst_idx_q, i);
    chk(wr_data_q, d);
  endtask : chk_wr

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_move();
    wq.push_back(rw(4'h2, 3'h7, 4'h1, 4'hF));
    step(2);
    chk(src_rd_q, 1'b1);
    chk(src_idx_q, 5'h0F);
    step(1);
    chk(src_rd_q, 1'b0);
    chk_wr(4'h2, 5'h07, regv(4'h1, 5'h0F));
  endtask : t_move

  task automatic t_prefix_imm();
    wq.push_back(im(M_PRE, 3'h0, 8'h12));
    wq.push_back(im(4'h1, 3'h2, 8'h34));
    wq.push_back(im(4'h1, 3'h2, 8'h56));
    step(3);
    chk(prefix_hold_register_q, 8'h12);
    chk(dst_wr_q, 1'b0);
    step(1);
    chk_wr(4'h1, 5'h02, 16'h1234);
    chk(prefix_written_q, 1'b0);
    step(1);
    chk_wr(4'h1, 5'h02, 16'h0056);
  endtask : t_prefix_imm

  task automatic t_stale();
    wq.push_back(im(M_PRE, 3'h0, 8'h77));
    wq.push_back(17'h00000);
    wq.push_back(im(4'h1, 3'h1, 8'h9A));
    step(5);
    chk_wr(4'h1, 5'h01, 16'h009A);
  endtask : t_stale

  task automatic t_branch();
    wq.push_back(im(MOD_SYS, IDX_BRANCH[2:0], 8'h20));
    wq.push_back(im(M_PRE, 3'h0, 8'h00));
    wq.push_back(im(MOD_SYS, IDX_BRANCH[2:0], 8'h20));
    step(3);
    chk(branch_q, 1'b1);
    chk(branch_abs_q, 1'b0);
    step(2);
    chk(branch_abs_q, 1'b1);
    chk(wr_data_q, 16'h0020);
  endtask : t_branch

  task automatic t_index();
    wq.push_back(im(M_PRE, 3'h3, 8'h00));
    wq.push_back(rw(4'h2, 3'h5, 4'h1, 4'h7));
    step(3);
    chk(src_idx_q, 5'h17);
    step(1);
    chk_wr(4'h2, 5'h0D, regv(4'h1, 5'h17));
  endtask : t_index

  // word AB80, views, both byte writes, refused swap write
  task automatic t_word_reg();
    wq.push_back(im(M_PRE, 3'h0, 8'hAB));
    wq.push_back(im(MOD_GRP, GRX_WORD[2:0], 8'h80));
    wq.push_back(17'h00000);
    wq.push_back(rw(4'h1, 3'h0, MOD_GRP, GRX_SWAP[3:0]));
    wq.push_back(rw(4'h1, 3'h1, MOD_GRP, GRX_SEXT[3:0]));
    wq.push_back(rw(4'h1, 3'h2, MOD_GRP, GRX_HIGH[3:0]));
    wq.push_back(rw(4'h1, 3'h3, MOD_GRP, GRX_LOW[3:0]));
    wq.push_back(im(MOD_GRP, GRX_HIGH[2:0], 8'h5C));
    wq.push_back(im(MOD_GRP, GRX_SWAP[2:0], 8'h11));
    wq.push_back(im(MOD_GRP, GRX_LOW[2:0], 8'h3D));
    wq.push_back(rw(4'h1, 3'h4, MOD_GRP, GRX_WORD[3:0]));
    step(4);
    chk(dst_wr_q, 1'b0);
    step(2);
    chk_wr(4'h1, 5'h00, 16'h80AB);
    step(1);
    chk_wr(4'h1, 5'h01, 16'hFF80);
    step(1);
    chk(wr_data_q[7:0], 8'hAB);
    step(1);
    chk(wr_data_q[7:0], 8'h80);
    step(4);
    chk_wr(4'h1, 5'h04, 16'h5C3D);
  endtask : t_word_reg

  task automatic t_high_byte();
    logic [DATA_W-1:0] v;
    v = regv(4'h1, 5'h06);
    wq.push_back(rw(MOD_GRP, GRX_WORD[2:0], 4'h1, 4'h6));
    wq.push_back(17'h00000);
    wq.push_back(rw(4'h2, 3'h1, MOD_GRP, GRX_HIGH[3:0]));
    step(5);
    chk(dst_wr_q, 1'b1);
    chk(wr_data_q[7:0], v[15:8]);
  endtask : t_high_byte

  task automatic t_indirect();
    wq.push_back(rw(4'h2, 3'h0, MOD_MEM, 4'h0));
    wq.push_back(17'h00000);
    wq.push_back(rw(4'h2, 3'h1, MOD_MEM, 4'h1));
    wq.push_back(17'h00000);
    wq.push_back(rw(4'h2, 3'h2, MOD_MEM, 4'h1));
    wq.push_back(im(MOD_MEM, 3'h0, 8'h3C));
    step(2);
    chk(mem_addr_q, PTR_BASE);
    chk(sp_pop_q, 1'b0);
    step(1);
    chk_wr(4'h2, 5'h00, PTR_BASE ^ 16'h5AA5);
    step(1);
    chk(sp_pop_q, 1'b1);
    chk(mem_addr_q, STK_BASE);
    step(2);
    chk(mem_rd_q, 1'b1);
    chk(mem_addr_q, STK_BASE - 16'h0001);
    step(1);
    chk_wr(4'h2, 5'h02, (STK_BASE - 16'h0001) ^ 16'h5AA5);
    step(1);
    chk(mem_wr_q, 1'b1);
    chk(mem_wr_addr_q, PTR_BASE + 16'h0001);
    chk(wr_data_q, 16'h003C);
  endtask : t_indirect

  // ************************************************************
  // verdict, watchdog, main sequence
  // ************************************************************
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // whole run needs about 51 cycles
  initial
  begin
    repeat (2000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    rstn = 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk(prefix_written_q, 1'b0);
    chk(dst_wr_q, 1'b0);
    t_move();
    t_prefix_imm();
    t_stale();
    t_branch();
    t_index();
    t_word_reg();
    t_high_byte();
    t_indirect();
    print_verdict();
  end

endmodule : prd_decode_bench

`default_nettype wire
